// file: src/rad_defines.svh
/*
  constants for the register adder datapath: widths, clear values, order
  register field positions.
  assumes it is included by bare name from the package and the design.
*/
`ifndef RAD_DEFINES_SVH
`define RAD_DEFINES_SVH

`define RAD_WORD_W 40
`define RAD_ALL_ONES 40'hff_ffff_ffff
`define RAD_ALL_ZEROS 40'h00_0000_0000
`define RAD_HALF_W 20
`define RAD_ADDR_W 10
`define RAD_EVEN_ADDR_LSB 20
`define RAD_ODD_ADDR_LSB 0
`define RAD_EVEN_ORDER_LSB 20
`define RAD_ODD_ORDER_LSB 0

`endif

// file: src/rad_pkg.sv
/*
  types for the register adder datapath.
  assumes rad_defines.svh is on the include path.
*/
`include "rad_defines.svh"

package rad_pkg;

  typedef enum logic [3:0] {
    RAD_SHIFT_NONE = 4'h0,
    RAD_CLEAR_TEMP = 4'h1,
    RAD_COPY_UP = 4'h2,
    RAD_CLEAR_LOWER = 4'h4,
    RAD_COPY_DOWN = 4'h8
  } rad_shift_step_t;

  // one control step from the sequencer; a strobe per clear or gate, with the subtract select alongside
  typedef struct packed {
    logic operand_clear_ones;
    logic operand_clear_zeros;
    logic memory_to_operand_gate;
    logic multiplier_to_operand_gate;
    logic instruction_clear_ones;
    logic memory_to_instruction_gate;
    logic odd_address_gate;
    logic mq_clear;
    logic memory_to_multiplier_gate;
    logic temp_clear;
    logic copy_up_to_temp;
    logic mq_clear_for_shift;
    logic copy_down_left;
    logic copy_down_right;
    logic subtract;
  } rad_ctrl_t;

endpackage

// file: src/rad_datapath.sv
/*
  register adder datapath: multiplier/quotient pair slaved to the
  accumulator pair, operand register, instruction pair register and a
  forty-column ripple adder.
  assumes the sequencer issues every clear and gate as its own step,
  and that the accumulator pair lives outside and shifts in the same step.
*/
`timescale 1ns/1ns
`include "rad_defines.svh"

module rad_datapath
  import rad_pkg::*;
#(
  parameter int WORD_W = `RAD_WORD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire rad_ctrl_t ctrl,
  input wire logic [WORD_W-1:0] memory_word,
  input wire logic [WORD_W-1:0] accumulator_reg,
  input wire logic quotient_digit,
  input wire logic [WORD_W-1:0] diag_fill,
  output logic [WORD_W-1:0] multiplier_quotient_reg,
  output logic [WORD_W-1:0] temp_reg,
  output logic [WORD_W-1:0] operand_reg,
  output logic [WORD_W-1:0] instruction_pair_reg,
  output logic [WORD_W-1:0] sum_word,
  output logic [`RAD_HALF_W-1:0] even_order,
  output logic [`RAD_HALF_W-1:0] odd_order,
  output logic [`RAD_ADDR_W-1:0] even_address,
  output logic sequence_error
);

  logic [WORD_W-1:0] incident;
  logic [WORD_W:0] carry;
  logic [WORD_W-1:0] next_sum;

  // one-sided gate: after clear to zero it sets ones, after ones clears
  function automatic logic [WORD_W-1:0] gate_ones(
    input logic [WORD_W-1:0] cur, input logic [WORD_W-1:0] src);
    gate_ones = cur | src;
  endfunction

  function automatic logic [WORD_W-1:0] gate_zeros(
    input logic [WORD_W-1:0] cur, input logic [WORD_W-1:0] src);
    gate_zeros = cur & src;
  endfunction

  // complement selector and ripple adder
  always_comb begin
    incident = ctrl.subtract ? ~operand_reg : operand_reg;
    carry = '0;
    carry[0] = ctrl.subtract;
    next_sum = '0;
    for (int i = 0; i < WORD_W; i++) begin
      next_sum[i] = accumulator_reg[i] ^ incident[i] ^ carry[i];
      carry[i+1] = (accumulator_reg[i] & incident[i]) |
                   (accumulator_reg[i] & carry[i]) |
                   (incident[i] & carry[i]);
    end
    // carry[WORD_W] is dropped on purpose: modulo arithmetic
  end

  // sum registered so the accumulator temp gate sees a stable word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sum_word <= '0;
    end else begin
      sum_word <= next_sum;
    end
  end

  // multiplier/quotient register; diagonal shifts follow the accumulator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multiplier_quotient_reg <= '0;
    end else if (ctrl.mq_clear || ctrl.mq_clear_for_shift) begin
      multiplier_quotient_reg <= `RAD_ALL_ZEROS;
    end else if (ctrl.memory_to_multiplier_gate) begin
      multiplier_quotient_reg <=
        gate_ones(multiplier_quotient_reg, memory_word);
    end else if (ctrl.copy_down_right) begin
      multiplier_quotient_reg <= gate_ones(multiplier_quotient_reg,
        {diag_fill[WORD_W-1], temp_reg[WORD_W-1:1]});
    end else if (ctrl.copy_down_left) begin
      multiplier_quotient_reg <= gate_ones(multiplier_quotient_reg,
        {temp_reg[WORD_W-2:0], quotient_digit});
    end
  end

  // temp register: only the straight-up copy loads it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      temp_reg <= '0;
    end else if (ctrl.temp_clear) begin
      temp_reg <= `RAD_ALL_ZEROS;
    end else if (ctrl.copy_up_to_temp) begin
      temp_reg <= gate_ones(temp_reg, multiplier_quotient_reg);
    end
  end

  // operand register: no path to the instruction register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_reg <= '0;
    end else if (ctrl.operand_clear_ones) begin
      operand_reg <= `RAD_ALL_ONES;
    end else if (ctrl.operand_clear_zeros) begin
      operand_reg <= `RAD_ALL_ZEROS;
    end else if (ctrl.memory_to_operand_gate) begin
      operand_reg <= gate_zeros(operand_reg, memory_word);
    end else if (ctrl.multiplier_to_operand_gate) begin
      operand_reg <=
        gate_ones(operand_reg, multiplier_quotient_reg);
    end
  end

  // instruction pair register, part of control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instruction_pair_reg <= '0;
    end else if (ctrl.instruction_clear_ones) begin
      instruction_pair_reg <= `RAD_ALL_ONES;
    end else if (ctrl.memory_to_instruction_gate) begin
      instruction_pair_reg <=
        gate_zeros(instruction_pair_reg, memory_word);
    end else if (ctrl.odd_address_gate) begin
      instruction_pair_reg[`RAD_EVEN_ADDR_LSB +: `RAD_ADDR_W] <=
        instruction_pair_reg[`RAD_ODD_ADDR_LSB +: `RAD_ADDR_W];
    end
  end

  // order outputs sampled from the register, one step late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      even_order <= '0;
      odd_order <= '0;
      even_address <= '0;
    end else begin
      even_order <=
        instruction_pair_reg[`RAD_EVEN_ORDER_LSB +: `RAD_HALF_W];
      odd_order <=
        instruction_pair_reg[`RAD_ODD_ORDER_LSB +: `RAD_HALF_W];
      even_address <=
        instruction_pair_reg[`RAD_EVEN_ADDR_LSB +: `RAD_ADDR_W];
    end
  end

  // flags a clear issued together with a gate of the same register, odd_address_gate excepted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sequence_error <= 1'b0;
    end else begin
      sequence_error <=
        ((ctrl.operand_clear_ones || ctrl.operand_clear_zeros) &&
         (ctrl.memory_to_operand_gate || ctrl.multiplier_to_operand_gate)) ||
        (ctrl.instruction_clear_ones && ctrl.memory_to_instruction_gate) ||
        (ctrl.temp_clear && ctrl.copy_up_to_temp) ||
        ((ctrl.mq_clear || ctrl.mq_clear_for_shift) &&
         (ctrl.copy_down_left || ctrl.copy_down_right ||
          ctrl.memory_to_multiplier_gate));
    end
  end

  a_operand_clear_ones: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.operand_clear_ones |=> operand_reg == `RAD_ALL_ONES)
    else $error("operand not all ones after clear");

  a_operand_mem_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.operand_clear_ones ##1 (ctrl.memory_to_operand_gate &&
      !ctrl.operand_clear_ones && !ctrl.operand_clear_zeros)
    |=> operand_reg == $past(memory_word))
    else $error("operand does not match memory word");

  a_operand_copy_mq: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.operand_clear_zeros ##1 (ctrl.multiplier_to_operand_gate &&
      !ctrl.operand_clear_ones && !ctrl.operand_clear_zeros &&
      !ctrl.memory_to_operand_gate)
    |=> operand_reg == $past(multiplier_quotient_reg))
    else $error("operand does not copy multiplier register");

  a_instr_load: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.instruction_clear_ones ##1 (ctrl.memory_to_instruction_gate &&
      !ctrl.instruction_clear_ones)
    |=> instruction_pair_reg == $past(memory_word))
    else $error("instruction pair not loaded from memory");

  a_sum_word: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> sum_word == $past(accumulator_reg) +
      ($past(ctrl.subtract) ? ~$past(operand_reg) + 40'h1
                            : $past(operand_reg)))
    else $error("sum word wrong");

  a_temp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl.temp_clear && !ctrl.copy_up_to_temp |=> $stable(temp_reg))
    else $error("temp register changed without its gate");

  a_even_addr: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> even_address ==
      $past(instruction_pair_reg[`RAD_EVEN_ADDR_LSB +: `RAD_ADDR_W]))
    else $error("even address not presented");

  a_shift_right: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.copy_down_right && !ctrl.mq_clear && !ctrl.mq_clear_for_shift &&
      !ctrl.memory_to_multiplier_gate && multiplier_quotient_reg == '0
    |=> multiplier_quotient_reg[WORD_W-2:0] ==
      $past(temp_reg[WORD_W-1:1]))
    else $error("right shift wrong");

  // multi-step transfers: clear step, then the gate that it pairs with
  sequence s_temp_load;
    ctrl.temp_clear ##1 (ctrl.copy_up_to_temp && !ctrl.temp_clear);
  endsequence

  sequence s_mq_load;
    ctrl.mq_clear ##1 (ctrl.memory_to_multiplier_gate &&
      !ctrl.mq_clear && !ctrl.mq_clear_for_shift);
  endsequence

  sequence s_shift_left;
    ctrl.mq_clear_for_shift ##1 (ctrl.copy_down_left &&
      !ctrl.mq_clear && !ctrl.mq_clear_for_shift &&
      !ctrl.memory_to_multiplier_gate && !ctrl.copy_down_right);
  endsequence

  a_temp_copy: assert property (@(posedge clk) disable iff (!rst_n)
    s_temp_load |=> temp_reg == $past(multiplier_quotient_reg))
    else $error("temp register not a straight copy");

  a_mq_load: assert property (@(posedge clk) disable iff (!rst_n)
    s_mq_load |=> multiplier_quotient_reg == $past(memory_word))
    else $error("multiplier register not loaded from memory");

  a_shift_left: assert property (@(posedge clk) disable iff (!rst_n)
    s_shift_left |=> multiplier_quotient_reg ==
      {$past(temp_reg[WORD_W-2:0]), $past(quotient_digit)})
    else $error("left shift wrong");

  a_mq_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.mq_clear || ctrl.mq_clear_for_shift
    |=> multiplier_quotient_reg == `RAD_ALL_ZEROS)
    else $error("multiplier register not cleared");

  a_operand_zeros: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.operand_clear_zeros && !ctrl.operand_clear_ones
    |=> operand_reg == `RAD_ALL_ZEROS)
    else $error("operand not all zeros after clear");

  a_operand_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl.operand_clear_ones && !ctrl.operand_clear_zeros &&
      !ctrl.memory_to_operand_gate && !ctrl.multiplier_to_operand_gate
    |=> $stable(operand_reg))
    else $error("operand changed without its own strobe");

  a_instr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.instruction_clear_ones
    |=> instruction_pair_reg == `RAD_ALL_ONES)
    else $error("instruction pair not all ones after clear");

  a_odd_addr_copy: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.odd_address_gate && !ctrl.instruction_clear_ones &&
      !ctrl.memory_to_instruction_gate
    |=> instruction_pair_reg[`RAD_EVEN_ADDR_LSB +: `RAD_ADDR_W] ==
      $past(instruction_pair_reg[`RAD_ODD_ADDR_LSB +: `RAD_ADDR_W]))
    else $error("odd address not copied to even field");

  a_order_outs: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> even_order ==
      $past(instruction_pair_reg[`RAD_EVEN_ORDER_LSB +: `RAD_HALF_W]) &&
      odd_order ==
      $past(instruction_pair_reg[`RAD_ODD_ORDER_LSB +: `RAD_HALF_W]))
    else $error("order outputs do not follow register");

  a_seq_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.operand_clear_ones && ctrl.memory_to_operand_gate
    |=> sequence_error)
    else $error("coincident clear and gate not flagged");

  a_seq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl == '0 |=> !sequence_error)
    else $error("sequence flag raised without a coincidence");

endmodule // rad_datapath

// file: tb/rad_seq_model.sv
/*
  sequencer model: issues a clear step, then its gate step.
  assumes go is raised off the rising edge and held over one edge.
*/
`timescale 1ns/1ns
module rad_seq_model
  import rad_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic sub,
  input wire rad_ctrl_t clr_step,
  input wire rad_ctrl_t gate_step,
  output rad_ctrl_t ctrl
);
  rad_ctrl_t st;
  logic [1:0] n;
  initial begin
    st = '0;
    n = 2'h0;
  end
  // the gate always trails its clear by one whole step
  always @(posedge clk) begin
    if (n == 2'h0 && go) begin
      st <= clr_step;
      n <= 2'h1;
    end else if (n == 2'h1) begin
      st <= gate_step;
      n <= 2'h2;
    end else begin
      st <= '0;
      n <= 2'h0;
    end
  end
  always_comb begin
    ctrl = st;
    ctrl.subtract = sub;
  end
endmodule // rad_seq_model

// file: tb/register_adder_datapath_tb.sv
/*
  bench for rad_datapath: each scenario drives the sequencer model.
  assumes rad_seq_model stands in for the control.
*/
`timescale 1ns/1ns
`include "rad_defines.svh"
module register_adder_datapath_tb import rad_pkg::*;;
  localparam int W = `RAD_WORD_W;
  logic clk, rst_n, go, sub, qd, err, err_mid;
  logic [W-1:0] mem, acc, fill, mq, tmp, op, ins, sum, old;
  logic [19:0] ev, od;
  logic [9:0] ea;
  rad_ctrl_t cs, gs, ctrl;
  int miscompares, checks_done;

  rad_seq_model seq (.clk(clk), .go(go), .sub(sub), .clr_step(cs),
    .gate_step(gs), .ctrl(ctrl));
  rad_datapath uut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl),
    .memory_word(mem), .accumulator_reg(acc), .quotient_digit(qd),
    .diag_fill(fill), .multiplier_quotient_reg(mq), .temp_reg(tmp),
    .operand_reg(op), .instruction_pair_reg(ins), .sum_word(sum),
    .even_order(ev), .odd_order(od), .even_address(ea),
    .sequence_error(err));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [W-1:0] e, input logic [W-1:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // registers show the gate's result when this returns
  task pair(input rad_ctrl_t c, input rad_ctrl_t g);
    cs = c;
    gs = g;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    @(negedge clk);
    err_mid = err;
    @(negedge clk);
  endtask

  task t_add(input logic [W-1:0] a, input logic [W-1:0] o, input logic s);
    mem = o;
    acc = a;
    sub = s;
    pair('{operand_clear_ones: 1, default: 0},
      '{memory_to_operand_gate: 1, default: 0});
    chk(o, op);
    @(negedge clk);
    chk(s ? a + ~o + 40'h1 : a + o, sum);
    sub = 1'b0;
    $display("adder case done");
  endtask

  task t_mq;
    old = ins;
    mem = 40'h0f_1e2d_3c4b;
    pair('{mq_clear: 1, default: 0},
      '{memory_to_multiplier_gate: 1, default: 0});
    chk(mem, mq);
    mem = ~mem;
    pair('{operand_clear_zeros: 1, default: 0},
      '{multiplier_to_operand_gate: 1, default: 0});
    chk(~mem, op);
    chk(old, ins);
    $display("multiplier load done");
  endtask

  task t_shift;
    old = mq;
    fill = 40'h80_0000_0000;
    pair('{temp_clear: 1, default: 0}, '{copy_up_to_temp: 1, default: 0});
    chk(old, tmp);
    pair('{mq_clear_for_shift: 1, default: 0},
      '{copy_down_right: 1, default: 0});
    chk({fill[39], old[39:1]}, mq);
    old = mq;
    qd = 1'b1;
    pair('{temp_clear: 1, default: 0}, '{copy_up_to_temp: 1, default: 0});
    pair('{mq_clear_for_shift: 1, default: 0},
      '{copy_down_left: 1, default: 0});
    chk({old[38:0], qd}, mq);
    $display("shift done");
  endtask

  task t_instr;
    mem = 40'hab_cde1_2345;
    pair('{instruction_clear_ones: 1, default: 0},
      '{memory_to_instruction_gate: 1, default: 0});
    chk(mem, ins);
    @(negedge clk);
    chk(40'(mem[39:20]), 40'(ev));
    chk(40'(mem[19:0]), 40'(od));
    chk(40'(mem[29:20]), 40'(ea));
    pair('0, '{odd_address_gate: 1, default: 0});
    chk({mem[39:30], mem[9:0], mem[19:0]}, ins);
    $display("instruction done");
  endtask

  task t_err;
    pair('{operand_clear_ones: 1, memory_to_operand_gate: 1, default: 0},
      '0);
    chk(40'h1, 40'(err_mid));
    chk(`RAD_ALL_ONES, op);
    $display("coincidence done");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run is some 64 cycles
  initial begin
    #100000;
    miscompares++;
    test_done;
  end

  initial begin
    {rst_n, go, sub, qd, err_mid} = '0;
    cs = '0;
    gs = '0;
    {mem, acc, fill} = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_add(`RAD_ALL_ONES, 40'h1, 1'b0);
    t_add(40'h12_3456_789a, 40'h0f_0f0f_0f0f, 1'b0);
    t_add(40'h5, 40'h3, 1'b1);
    t_add(40'h3, 40'h5, 1'b1);
    t_mq;
    t_shift;
    t_instr;
    t_err;
    test_done;
  end
endmodule // register_adder_datapath_tb
